//--- verilog/rcd_datapath.sv
// Functional notes
// - Class from bits 15..11, operation from bits 10..3.
// - Only A and X are touched; no memory operand read.
// - Overflow flag is left unchanged by every operation here.
// - Switch reads arrive as input transfers, device 0, function 1.
// - 0110 clears A, X unchanged.
// - 0108 clears X, A unchanged.
// - 0118 clears both A and X.
// - 0010 loads A with all ones.
// - 0008 loads X with all ones.
// - 0018 loads A and X with all ones.
// - 0350 loads A with plus one.
// - 0528 loads X with plus one.
// - 0358 loads A and X with plus one.
`timescale 1ns/1ps
`default_nettype none
module rcd_datapath (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // Instruction issue from sequencer
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        io_valid,
  input  wire logic        io_unconditional,
  input  wire logic        io_is_input,
  input  wire logic [7:0]  io_device,
  input  wire logic [2:0]  io_function,
  input  wire logic        io_to_second,
  // Data switch pins
  input  wire logic [15:0] switch_pins,
  // Register file and flag
  output logic [15:0]      first_work_q,
  output logic [15:0]      second_work_q,
  output logic             wrap_flag_q,
  output logic             done_q,
  output logic             illegal_q
);
  logic [15:0]      sw_meta_q;
  logic [15:0]      sw_sync_q;
  logic [15:0]      first_work_d;
  logic [15:0]      second_work_d;
  logic             done_d;
  logic             illegal_d;
  logic             is_class;
  logic             sw_hit;
  rcd_pkg::rcd_wr_t wr;

  // Switch pins are asynchronous, so they pass two flops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sw_meta_q <= rcd_pkg::RST_WORD;
      sw_sync_q <= rcd_pkg::RST_WORD;
    end
    else if (clk_en)
    begin
      sw_meta_q <= switch_pins;
      sw_sync_q <= sw_meta_q;
    end
  end

  // Class decode on the top field
  assign is_class = instr_valid &&
    (instr_word[rcd_pkg::CLASS_HI:rcd_pkg::CLASS_LO] == rcd_pkg::CLASS_CODE);

  // Switch reads come only through the input path
  assign sw_hit = io_valid && io_unconditional && io_is_input &&
    (io_device == rcd_pkg::IO_DEVICE_SW) && (io_function == rcd_pkg::IO_FUNC_SW);

  // Operation decode: bits 2..0 are masked off, so only the 8-bit field picks the op
  always_comb
  begin
    wr = '{first_we: 1'b0, first_val: rcd_pkg::VAL_ZERO,
           second_we: 1'b0, second_val: rcd_pkg::VAL_ZERO};
    illegal_d = 1'b0;
    if (is_class)
    begin
      unique case ({instr_word[rcd_pkg::CLASS_HI:rcd_pkg::OPF_LO], 3'h0})
        rcd_pkg::OP_CLEAR_FIRST:   wr.first_we = 1'b1;
        rcd_pkg::OP_CLEAR_SECOND:  wr.second_we = 1'b1;
        rcd_pkg::OP_CLEAR_BOTH:
        begin
          wr.first_we  = 1'b1;
          wr.second_we = 1'b1;
        end
        rcd_pkg::OP_NEG_ONE_FIRST:
        begin
          wr.first_we  = 1'b1;
          wr.first_val = rcd_pkg::VAL_NEG_ONE;
        end
        rcd_pkg::OP_NEG_ONE_SEC:
        begin
          wr.second_we  = 1'b1;
          wr.second_val = rcd_pkg::VAL_NEG_ONE;
        end
        rcd_pkg::OP_NEG_ONE_BOTH:
        begin
          wr.first_we   = 1'b1;
          wr.first_val  = rcd_pkg::VAL_NEG_ONE;
          wr.second_we  = 1'b1;
          wr.second_val = rcd_pkg::VAL_NEG_ONE;
        end
        rcd_pkg::OP_POS_ONE_FIRST:
        begin
          wr.first_we  = 1'b1;
          wr.first_val = rcd_pkg::VAL_POS_ONE;
        end
        rcd_pkg::OP_POS_ONE_SEC:
        begin
          wr.second_we  = 1'b1;
          wr.second_val = rcd_pkg::VAL_POS_ONE;
        end
        rcd_pkg::OP_POS_ONE_BOTH:
        begin
          wr.first_we   = 1'b1;
          wr.first_val  = rcd_pkg::VAL_POS_ONE;
          wr.second_we  = 1'b1;
          wr.second_val = rcd_pkg::VAL_POS_ONE;
        end
        // Unlisted operation codes in this class are flagged, not executed
        default:                   illegal_d = 1'b1;
      endcase
    end
    else if (sw_hit)
    begin
      wr.first_we   = !io_to_second;
      wr.first_val  = sw_sync_q;
      wr.second_we  = io_to_second;
      wr.second_val = sw_sync_q;
    end
  end

  // Next register values; loaded from a constant or the switch word, otherwise held
  always_comb
  begin
    first_work_d  = wr.first_we ? wr.first_val : first_work_q;
    second_work_d = wr.second_we ? wr.second_val : second_work_q;
    done_d        = is_class || sw_hit;
  end

  // One-cycle update; the flag has no writer here by design
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      first_work_q  <= rcd_pkg::RST_WORD;
      second_work_q <= rcd_pkg::RST_WORD;
      wrap_flag_q   <= 1'b0;
      done_q        <= 1'b0;
      illegal_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      first_work_q  <= first_work_d;
      second_work_q <= second_work_d;
      wrap_flag_q   <= wrap_flag_q;
      done_q        <= done_d;
      illegal_q     <= illegal_d;
    end
  end

  // Checks
  a_clear_first_only: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_CLEAR_FIRST) |=>
      (first_work_q == rcd_pkg::VAL_ZERO) && $stable(second_work_q))
    else $error("Clear of A wrong or X disturbed");
  a_clear_second_only: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_CLEAR_SECOND) |=>
      (second_work_q == rcd_pkg::VAL_ZERO) && $stable(first_work_q))
    else $error("Clear of X wrong or A disturbed");
  a_clear_both_regs: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_CLEAR_BOTH) |=>
      (first_work_q == 16'h0000) && (second_work_q == 16'h0000))
    else $error("Clear of both failed");
  a_neg_first_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_NEG_ONE_FIRST) |=>
      (first_work_q == 16'hffff) && $stable(second_work_q))
    else $error("Minus one into A failed");
  a_neg_second_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_NEG_ONE_SEC) |=>
      (second_work_q == 16'hffff) && $stable(first_work_q))
    else $error("Minus one into X failed");
  a_neg_both_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_NEG_ONE_BOTH) |=>
      (first_work_q == 16'hffff) && (second_work_q == 16'hffff))
    else $error("Minus one into both failed");
  a_pos_first_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_POS_ONE_FIRST) |=>
      (first_work_q == 16'h0001) && $stable(second_work_q))
    else $error("Plus one into A failed");
  a_pos_second_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_POS_ONE_SEC) |=>
      (second_work_q == 16'h0001) && $stable(first_work_q))
    else $error("Plus one into X failed");
  a_pos_both_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word == rcd_pkg::OP_POS_ONE_BOTH) |=>
      (first_work_q == 16'h0001) && (second_work_q == 16'h0001))
    else $error("Plus one into both failed");
  a_flag_held: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 $stable(wrap_flag_q))
    else $error("Overflow flag changed");
  a_done_one_cycle: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word[15:11] == 5'h00) |=> done_q)
    else $error("Completion not seen next cycle");
  a_other_class_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word[15:11] != 5'h00 && !io_valid) |=>
      $stable(first_work_q) && $stable(second_work_q))
    else $error("Other class changed A or X");
  a_switch_into_first: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && !(instr_valid && instr_word[15:11] == 5'h00) && io_valid &&
     io_unconditional && io_is_input && io_device == 8'h00 && io_function == 3'h1 &&
     !io_to_second) |=> (first_work_q == $past(sw_sync_q)))
    else $error("Switch read into A failed");
  // Mirror of the read into A; the other register must not move
  a_switch_into_second: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && !(instr_valid && instr_word[15:11] == 5'h00) && io_valid &&
     io_unconditional && io_is_input && io_device == 8'h00 && io_function == 3'h1 &&
     io_to_second) |=> (second_work_q == $past(sw_sync_q)) && $stable(first_work_q))
    else $error("Switch read into X failed");
  // No listed code has an all-ones low field, so such a word must be refused
  a_unlisted_refused: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && instr_valid && instr_word[15:11] == 5'h00 && instr_word[7:3] == 5'h1f) |=>
      illegal_q && $stable(first_work_q) && $stable(second_work_q))
    else $error("Unlisted class word was executed");
  // A stalled cycle must leave A, X and done where they were
  a_stall_freezes: assert property (@(posedge core_clk) disable iff (!resetn)
    !clk_en |=> $stable(first_work_q) && $stable(second_work_q) && $stable(done_q))
    else $error("State moved while clock enable was low");
endmodule
`default_nettype wire

//--- verilog/rcd_pkg.sv
package rcd_pkg;
  // Word and field layout
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CLASS_HI   = 15;
  localparam int unsigned CLASS_LO   = 11;
  localparam int unsigned OPF_HI     = 10;
  localparam int unsigned OPF_LO     = 3;
  localparam logic [4:0]  CLASS_CODE = 5'h00;

  // Opcodes of the set and clear group
  localparam logic [15:0] OP_CLEAR_FIRST   = 16'h0110;
  localparam logic [15:0] OP_CLEAR_SECOND  = 16'h0108;
  localparam logic [15:0] OP_CLEAR_BOTH    = 16'h0118;
  localparam logic [15:0] OP_NEG_ONE_FIRST = 16'h0010;
  localparam logic [15:0] OP_NEG_ONE_SEC   = 16'h0008;
  localparam logic [15:0] OP_NEG_ONE_BOTH  = 16'h0018;
  localparam logic [15:0] OP_POS_ONE_FIRST = 16'h0350;
  localparam logic [15:0] OP_POS_ONE_SEC   = 16'h0528;
  localparam logic [15:0] OP_POS_ONE_BOTH  = 16'h0358;

  // Constant values loaded
  localparam logic [15:0] VAL_ZERO    = 16'h0000;
  localparam logic [15:0] VAL_NEG_ONE = 16'hffff;
  localparam logic [15:0] VAL_POS_ONE = 16'h0001;

  // Switch input decode: unconditional input, device 0, function 1
  localparam logic [7:0]  IO_DEVICE_SW = 8'h00;
  localparam logic [2:0]  IO_FUNC_SW   = 3'h1;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Register write result
  typedef struct packed {
    logic        first_we;
    logic [15:0] first_val;
    logic        second_we;
    logic [15:0] second_val;
  } rcd_wr_t;
endpackage

//--- tb/rcd_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcd_seq_model (
  // Requests from the bench
  input  wire logic        issue_valid,
  input  wire logic [15:0] issue_word,
  input  wire logic        sw_req,
  input  wire logic        sw_second,
  // Issue lines towards the datapath
  output logic             instr_valid,
  output logic [15:0]      instr_word,
  output logic             io_valid,
  output logic             io_unconditional,
  output logic             io_is_input,
  output logic [7:0]       io_device,
  output logic [2:0]       io_function,
  output logic             io_to_second
);
  // Idle word, device and function lines show the inverse, so a stale word can never pass for a live one
  always_comb
  begin
    instr_valid      = issue_valid;
    instr_word       = issue_valid ? issue_word : ~issue_word;
    io_valid         = sw_req;
    io_unconditional = sw_req;
    io_is_input      = sw_req;
    io_device        = sw_req ? rcd_pkg::IO_DEVICE_SW : ~rcd_pkg::IO_DEVICE_SW;
    io_function      = sw_req ? rcd_pkg::IO_FUNC_SW : ~rcd_pkg::IO_FUNC_SW;
    io_to_second     = sw_second;
  end
endmodule
`default_nettype wire

//--- tb/test_register_change_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module test_register_change_datapath;
  logic        core_clk, resetn, clk_en, iv, sreq, ssec, ivd, iov, iou, ioi, io2;
  logic        wrap_flag_q, done_q, illegal_q, ed, ei;
  logic [15:0] iw, pins, iwd, first_work_q, second_work_q, ea, ex, w;
  logic [7:0]  iodev;
  logic [2:0]  iofn;
  logic [31:0] seed, r;
  int          num_errors, n_tests;
  logic [15:0] ops [9] = '{16'h0110, 16'h0108, 16'h0118, 16'h0010, 16'h0008,
                           16'h0018, 16'h0350, 16'h0528, 16'h0358};
  rcd_seq_model rcd_seq_model_inst (.issue_valid(iv), .issue_word(iw), .sw_req(sreq),
    .sw_second(ssec), .instr_valid(ivd), .instr_word(iwd), .io_valid(iov),
    .io_unconditional(iou), .io_is_input(ioi), .io_device(iodev), .io_function(iofn),
    .io_to_second(io2));
  rcd_datapath rcd_datapath_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .instr_valid(ivd), .instr_word(iwd), .io_valid(iov), .io_unconditional(iou),
    .io_is_input(ioi), .io_device(iodev), .io_function(iofn), .io_to_second(io2),
    .switch_pins(pins), .first_work_q(first_work_q), .second_work_q(second_work_q),
    .wrap_flag_q(wrap_flag_q), .done_q(done_q), .illegal_q(illegal_q));
  // Fixed-seed xorshift keeps every run repeatable
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Called at a rising edge; checks the previous op, then models this one
  task automatic go(logic v, logic [15:0] wd, logic s, logic t2, logic en);
    iv     <= v;
    iw     <= wd;
    sreq   <= s;
    ssec   <= t2;
    clk_en <= en;
    @(negedge core_clk);
    chk(first_work_q, ea);
    chk(second_work_q, ex);
    chk({15'h0, done_q}, {15'h0, ed});
    chk({15'h0, illegal_q}, {15'h0, ei});
    chk({15'h0, wrap_flag_q}, 16'h0000);
    if (en)
    begin
      ed = 1'b0;
      ei = 1'b0;
      if (v && wd[15:11] === 5'h00)
      begin
        // Any class word completes; bits 2..0 take no part in the choice
        ed = 1'b1;
        case ({wd[15:3], 3'h0})
          16'h0110: ea = 16'h0000;
          16'h0108: ex = 16'h0000;
          16'h0118:
          begin
            ea = 16'h0000;
            ex = 16'h0000;
          end
          16'h0010: ea = 16'hffff;
          16'h0008: ex = 16'hffff;
          16'h0018:
          begin
            ea = 16'hffff;
            ex = 16'hffff;
          end
          16'h0350: ea = 16'h0001;
          16'h0528: ex = 16'h0001;
          16'h0358:
          begin
            ea = 16'h0001;
            ex = 16'h0001;
          end
          default: ei = 1'b1;
        endcase
      end
      else if (s)
      begin
        ed = 1'b1;
        if (t2) ex = pins;
        else ea = pins;
      end
    end
    @(posedge core_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // A hang is cut after about thirty times the expected run
  initial
  begin
    #40000;
    num_errors++;
    conclude();
  end
  // Main sequence
  initial
  begin
    resetn     = 1'b0;
    clk_en     = 1'b0;
    iv         = 1'b0;
    sreq       = 1'b0;
    ssec       = 1'b0;
    iw         = 16'h0000;
    pins       = 16'h0000;
    ea         = 16'h0000;
    ex         = 16'h0000;
    ed         = 1'b0;
    ei         = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    seed       = 32'h6fc118a4;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // Every set and clear code, back to back, both directions
    for (int i = 0; i < 18; i++) go(1'b1, ops[i < 9 ? i : 17 - i], 1'b0, 1'b0, 1'b1);
    $display("test codes done");
    // Switch reads into each register, then a collision with a class word
    r = xs();
    pins <= r[15:0];
    repeat (3) go(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1);
    go(1'b0, 16'h0000, 1'b1, 1'b0, 1'b1);
    go(1'b0, 16'h0000, 1'b1, 1'b1, 1'b1);
    go(1'b1, 16'h0350, 1'b1, 1'b1, 1'b1);
    $display("test switches done");
    // Random words, codes, switch reads and stalls
    for (int i = 0; i < 300; i++)
    begin
      r = xs();
      w = r[16] ? {5'h00, r[10:0]} : r[15:0];
      if (r[17]) w = ops[r[27:24] % 9];
      go(r[20], w, r[21], r[18], r[22] | r[23]);
    end
    go(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1);
    $display("test random done");
    // Reset in mid-run clears both registers
    resetn <= 1'b0;
    @(negedge core_clk);
    ea = 16'h0000;
    ex = 16'h0000;
    ed = 1'b0;
    ei = 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    go(1'b1, 16'h0018, 1'b0, 1'b0, 1'b1);
    go(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
